// ===== pspl_cfg.svh
// Constants for the PHY status and master loopback port block
`ifndef PSPL_CFG_SVH
`define PSPL_CFG_SVH

`define PSPL_LANES     4
`define PSPL_SLICE     16
`define PSPL_KPL       2
`define PSPL_DW        64
`define PSPL_KW        8
`define PSPL_SLICE_X1  16

`define PSPL_WID_NONE  3'h0
`define PSPL_WID_X1    3'h1
`define PSPL_WID_X2    3'h2
`define PSPL_WID_X4    3'h4

`define PSPL_MASK_X4   4'hF
`define PSPL_MASK_X2   4'h3
`define PSPL_MASK_X1   4'h1

`define PSPL_ZERO_D    64'h0000_0000_0000_0000
`define PSPL_ZERO_K    8'h00
`define PSPL_ZERO_L    4'h0

`endif

// ===== pspl_pkg.sv
// Types and shared functions of the PHY status and master loopback port block
`include "pspl_cfg.svh"

package pspl_pkg;

  // Build configuration of the core
  typedef enum logic [1:0]
  {
    PSPL_G1_X4 = 2'b00,  // 2.5G native x4, downgraded x1/x2
    PSPL_G1_X1 = 2'b01,  // 2.5G native x1
    PSPL_G2_X2 = 2'b10   // 5G native x2, downgraded x1
  } pspl_build_type;

  // Link trainer main state codes
  typedef enum logic [3:0]
  {
    PSPL_DETECT   = 4'b0000,
    PSPL_POLLING  = 4'b0001,
    PSPL_CONFIG   = 4'b0010,
    PSPL_L0       = 4'b0011,
    PSPL_L0S      = 4'b0100,
    PSPL_L1       = 4'b0101,
    PSPL_L2       = 4'b0110,
    PSPL_RECOVERY = 4'b0111,
    PSPL_LOOPBACK = 4'b1000,
    PSPL_HOTRESET = 4'b1001,
    PSPL_DISABLED = 4'b1010
  } pspl_ltssm_type;

  // Lanes that exist in a given build
  function automatic logic [`PSPL_LANES-1:0] laneMask(input pspl_build_type build);
    case (build)
      PSPL_G1_X4: laneMask = `PSPL_MASK_X4;
      PSPL_G2_X2: laneMask = `PSPL_MASK_X2;
      default:    laneMask = `PSPL_MASK_X1;
    endcase
  endfunction

  // One-hot width code from the set of included lanes
  function automatic logic [2:0] widthCode(input logic [`PSPL_LANES-1:0] lanes);
    case (lanes)
      `PSPL_MASK_X4: widthCode = `PSPL_WID_X4;
      `PSPL_MASK_X2: widthCode = `PSPL_WID_X2;
      `PSPL_MASK_X1: widthCode = `PSPL_WID_X1;
      default:       widthCode = `PSPL_WID_NONE;
    endcase
  endfunction

endpackage

// ===== pspl_lane_if.sv
// Raw and lane-trimmed loopback word passed between the port and its trimmer
`timescale 1ns/10ps
`include "pspl_cfg.svh"

interface pspl_lane_if;
  logic [`PSPL_DW-1:0]    rawData;  // Word as offered
  logic [`PSPL_KW-1:0]    rawK;     // K flags as offered
  logic [`PSPL_LANES-1:0] laneEn;   // Lanes present in this build
  logic [`PSPL_DW-1:0]    cutData;  // Word with absent lanes zeroed
  logic [`PSPL_KW-1:0]    cutK;     // K flags with absent lanes zeroed

  // Side that offers the word
  modport feed
  (
    output rawData,
    output rawK,
    output laneEn,
    input  cutData,
    input  cutK
  );

  // Side that trims the word
  modport trim
  (
    input  rawData,
    input  rawK,
    input  laneEn,
    output cutData,
    output cutK
  );
endinterface

// ===== pspl_lane_cut.sv
// Zeroes the 16-bit lane slices and K flag pairs of lanes absent from the build
`timescale 1ns/10ps
`include "pspl_cfg.svh"

module pspl_lane_cut
(
  pspl_lane_if.trim lane  // Word to trim
);

  // Keep each slice only when its lane exists; lane 0 is the low slice
  always_comb
  begin
    lane.cutData = `PSPL_ZERO_D;
    lane.cutK    = `PSPL_ZERO_K;
    for (int i = 0; i < `PSPL_LANES; i++)
    begin
      if (lane.laneEn[i])
      begin
        lane.cutData[i*`PSPL_SLICE +: `PSPL_SLICE] = lane.rawData[i*`PSPL_SLICE +: `PSPL_SLICE];
        lane.cutK[i*`PSPL_KPL +: `PSPL_KPL]        = lane.rawK[i*`PSPL_KPL +: `PSPL_KPL];
      end
    end
  end

endmodule

// ===== pspl_phy_status.sv
// PHY status outputs and master loopback data port of the endpoint core
//
// Notes on behaviour
// RL1: Inclusion vector bit 0 reports highest lane.
// RL2: 5G build drives only two inclusion bits.
// RL3: Width code one-hot: 000, 001, 010, 100.
// RL4: Width code absent (zero) in native x1 build.
// RL5: Compliance flag high during Polling.Compliance.
// RL6: Transmit ready output gates user loopback data.
// RL7: Loopback ports live only when option enabled.
// RL8: User gives two K flags per slice.
// RL9: User places lane 3 in top slice.
// RL10: Native x1 uses 16 bits, two K flags.
// RL11: Receive K flags two bits per slice.
// RL12: Receive word lane 3 top, lane 0 bottom.
// RL13: Inclusion bit high in Config when lane included.
// RL14: User changes transmit word only while ready.
`timescale 1ns/10ps
`include "pspl_cfg.svh"

module pspl_phy_status
#(
  parameter pspl_pkg::pspl_build_type BUILD       = pspl_pkg::PSPL_G1_X4,  // Build configuration
  parameter bit                       LOOPBACK_EN = 1'b1                   // Master loopback option
)
(
  input  wire logic                     clock,             // Core clock
  input  wire logic                     rst_n,             // Synchronous reset, active low
  input  wire pspl_pkg::pspl_ltssm_type trainState,        // Link trainer main state
  input  wire logic                     pollSubCompliance, // Trainer is in the Compliance substate
  input  wire logic [`PSPL_LANES-1:0]   laneIncluded,      // Lanes in width negotiation, lane order
  input  wire logic                     laneTxReady,       // Lanes can take a loopback word
  input  wire logic [`PSPL_DW-1:0]      laneRxData,        // Loopback word from the lanes
  input  wire logic [`PSPL_KW-1:0]      laneRxK,           // K flags from the lanes
  input  wire logic [`PSPL_DW-1:0]      txLbkData,         // User loopback word
  input  wire logic [`PSPL_KW-1:0]      txLbkK,            // User loopback K flags
  output logic      [`PSPL_LANES-1:0]   cfgLaneIncl_ff,    // Lane inclusion status, reversed order
  output logic      [2:0]               linkWidth_ff,      // One-hot link width code
  output logic                          polCompliance_ff,  // Polling.Compliance indicator
  output logic                          txLbkReady_ff,     // Transmit loopback ready
  output logic      [`PSPL_DW-1:0]      rxLbkData_ff,      // Received loopback word
  output logic      [`PSPL_KW-1:0]      rxLbkK_ff,         // Received loopback K flags
  output logic      [`PSPL_DW-1:0]      laneTxData_ff,     // Loopback word toward the lanes
  output logic      [`PSPL_KW-1:0]      laneTxK_ff,        // Loopback K flags toward the lanes
  output logic                          laneTxValid_ff     // Word toward the lanes is new
);

  // Lanes that exist in this build
  localparam logic [`PSPL_LANES-1:0] LANE_EN = pspl_pkg::laneMask(BUILD);

  pspl_lane_if txLane ();  // User word trimmed to the build
  pspl_lane_if rxLane ();  // Lane word trimmed to the build

  logic [`PSPL_LANES-1:0] inclLanes;       // Included lanes that exist
  logic [`PSPL_LANES-1:0] nxt_cfgLaneIncl; // Next inclusion vector
  logic [2:0]             nxt_linkWidth;   // Next width code
  logic                   nxt_txLbkReady;  // Next ready
  logic                   inConfig;        // Trainer is in Config

  assign inConfig  = (trainState == pspl_pkg::PSPL_CONFIG);
  assign inclLanes = laneIncluded & LANE_EN;

  // Feed the trimmers
  assign txLane.rawData = txLbkData;
  assign txLane.rawK    = txLbkK;
  assign txLane.laneEn  = LANE_EN;
  assign rxLane.rawData = laneRxData;
  assign rxLane.rawK    = laneRxK;
  assign rxLane.laneEn  = LANE_EN;

  // Absent lanes never reach either side of the loopback path
  pspl_lane_cut txCut
  (
    .lane (txLane.trim)
  );

  pspl_lane_cut rxCut
  (
    .lane (rxLane.trim)
  );

  // Inclusion vector: bit i reports the lane counted down from the top present lane
  always_comb
  begin
    nxt_cfgLaneIncl = `PSPL_ZERO_L;
    for (int i = 0; i < `PSPL_LANES; i++)
    begin
      // Only present lanes map; upper bits of a narrow build stay low
      if (LANE_EN[i] && inConfig)  // RL13
      begin
        case (BUILD)
          pspl_pkg::PSPL_G2_X2: nxt_cfgLaneIncl[i] = inclLanes[1-i];  // RL2
          pspl_pkg::PSPL_G1_X1: nxt_cfgLaneIncl[i] = inclLanes[i];
          default:              nxt_cfgLaneIncl[i] = inclLanes[`PSPL_LANES-1-i];  // RL1
        endcase
      end
    end
  end

  // Inclusion status register
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      cfgLaneIncl_ff <= `PSPL_ZERO_L;
    else
      cfgLaneIncl_ff <= nxt_cfgLaneIncl;
  end

  // Width code: zero in the native x1 build; otherwise cleared in Detect, tracked in Config, held elsewhere
  always_comb
  begin
    if (BUILD == pspl_pkg::PSPL_G1_X1)
      nxt_linkWidth = `PSPL_WID_NONE;  // RL4
    else if (trainState == pspl_pkg::PSPL_DETECT)
      nxt_linkWidth = `PSPL_WID_NONE;  // RL3
    else if (inConfig)
      nxt_linkWidth = pspl_pkg::widthCode(inclLanes);  // RL3
    else
      nxt_linkWidth = linkWidth_ff;
  end

  // Width code register
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      linkWidth_ff <= `PSPL_WID_NONE;
    else
      linkWidth_ff <= nxt_linkWidth;
  end

  // Compliance indicator follows the substate one cycle late
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      polCompliance_ff <= 1'b0;
    else
      polCompliance_ff <= (trainState == pspl_pkg::PSPL_POLLING) && pollSubCompliance;  // RL5
  end

  // Ready only in Loopback, with the option built and the lanes able to take data
  assign nxt_txLbkReady = LOOPBACK_EN && (trainState == pspl_pkg::PSPL_LOOPBACK) && laneTxReady;  // RL6 RL7

  // Ready register
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      txLbkReady_ff <= 1'b0;
    else
      txLbkReady_ff <= nxt_txLbkReady;
  end

  // Transmit capture: the user word is taken only in cycles where ready shows high
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      laneTxData_ff  <= `PSPL_ZERO_D;
      laneTxK_ff     <= `PSPL_ZERO_K;
      laneTxValid_ff <= 1'b0;
    end
    else
    begin
      laneTxValid_ff <= txLbkReady_ff;  // RL14
      // Words outside ready are ignored; last word stays on the lanes
      if (txLbkReady_ff)
      begin
        laneTxData_ff <= txLane.cutData;  // RL9 RL10
        laneTxK_ff    <= txLane.cutK;     // RL8
      end
    end
  end

  // Receive path: lane slices in order, zero when the option is not built
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rxLbkData_ff <= `PSPL_ZERO_D;
      rxLbkK_ff    <= `PSPL_ZERO_K;
    end
    else if (LOOPBACK_EN)  // RL7
    begin
      rxLbkData_ff <= rxLane.cutData;  // RL12 RL10
      rxLbkK_ff    <= rxLane.cutK;     // RL11
    end
    else
    begin
      rxLbkData_ff <= `PSPL_ZERO_D;
      rxLbkK_ff    <= `PSPL_ZERO_K;
    end
  end

  // Checks
  sequence s_offered;
    txLbkReady_ff;
  endsequence

  sequence s_taken;
    laneTxValid_ff && (laneTxData_ff[`PSPL_SLICE_X1-1:0] == $past(txLbkData[`PSPL_SLICE_X1-1:0]));
  endsequence

  a_incl_top_lane: assert property (@(posedge clock) disable iff (!rst_n)  // RL1
    (inConfig && BUILD == pspl_pkg::PSPL_G1_X4) |=> (cfgLaneIncl_ff[0] == $past(laneIncluded[3])))
    else $error("inclusion bit 0 does not follow lane 3");

  a_incl_low_lane: assert property (@(posedge clock) disable iff (!rst_n)  // RL13
    (inConfig && BUILD == pspl_pkg::PSPL_G1_X4) |=> (cfgLaneIncl_ff[3] == $past(laneIncluded[0])))
    else $error("inclusion bit 3 does not follow lane 0");

  a_incl_outside: assert property (@(posedge clock) disable iff (!rst_n)  // RL13
    !inConfig |=> (cfgLaneIncl_ff == `PSPL_ZERO_L))
    else $error("inclusion vector set outside Config");

  a_incl_narrow: assert property (@(posedge clock) disable iff (!rst_n)  // RL2
    (BUILD == pspl_pkg::PSPL_G2_X2) |-> (cfgLaneIncl_ff[3:2] == 2'h0))
    else $error("upper inclusion bits set in two-lane build");

  a_width_full: assert property (@(posedge clock) disable iff (!rst_n)  // RL3
    (inConfig && BUILD == pspl_pkg::PSPL_G1_X4 && laneIncluded == `PSPL_MASK_X4) |=> (linkWidth_ff == `PSPL_WID_X4))
    else $error("four included lanes not reported as width 4");

  a_width_hold: assert property (@(posedge clock) disable iff (!rst_n)  // RL3
    (!inConfig && trainState != pspl_pkg::PSPL_DETECT) |=> $stable(linkWidth_ff))
    else $error("width code changed outside Detect and Config");

  a_width_absent: assert property (@(posedge clock) disable iff (!rst_n)  // RL4
    (BUILD == pspl_pkg::PSPL_G1_X1) |-> (linkWidth_ff == `PSPL_WID_NONE))
    else $error("width code driven in single-lane build");

  a_pol_flag: assert property (@(posedge clock) disable iff (!rst_n)  // RL5
    ((trainState == pspl_pkg::PSPL_POLLING) && pollSubCompliance) |=> polCompliance_ff)
    else $error("compliance flag missing");

  a_rdy_gate: assert property (@(posedge clock) disable iff (!rst_n)  // RL6
    txLbkReady_ff |-> (LOOPBACK_EN && $past(trainState == pspl_pkg::PSPL_LOOPBACK) && $past(laneTxReady)))
    else $error("ready without loopback state and lane readiness");

  a_tx_capture: assert property (@(posedge clock) disable iff (!rst_n)  // RL14
    s_offered |=> s_taken)
    else $error("offered word not passed to the lanes");

  a_rx_pass: assert property (@(posedge clock) disable iff (!rst_n)  // RL12
    (LOOPBACK_EN && BUILD == pspl_pkg::PSPL_G1_X4) |=> (rxLbkData_ff == $past(laneRxData) && rxLbkK_ff == $past(laneRxK)))
    else $error("received word not passed in lane order");

  a_rx_x1_upper: assert property (@(posedge clock) disable iff (!rst_n)  // RL10
    (BUILD == pspl_pkg::PSPL_G1_X1) |-> (rxLbkData_ff[`PSPL_DW-1:`PSPL_SLICE_X1] == 48'h0000_0000_0000))
    else $error("upper slices live in single-lane build");

endmodule

// ===== pspl_lbk_user.sv
// Transmit loopback source standing in for the user logic
`timescale 1ns/10ps
`include "pspl_cfg.svh"

module pspl_lbk_user
(
  input  wire logic                clock,   // Core clock
  input  wire logic                rst_n,   // Synchronous reset, active low
  input  wire logic                ready,   // Transmit loopback ready from the core
  output logic      [`PSPL_DW-1:0] txData,  // Loopback word, lane 3 in the top slice
  output logic      [`PSPL_KW-1:0] txK      // K flag pair per slice
);
  logic taken;  // Word was taken at the last rising edge

  // Notes whether the core took the word at this edge
  always @(posedge clock)
    taken <= rst_n && ready;

  // Zero word in reset; fresh word only after a take, otherwise the old one is held
  always @(negedge clock)
  begin
    if (!rst_n)
    begin
      txData = `PSPL_ZERO_D;
      txK = `PSPL_ZERO_K;
    end
    else if (taken)
    begin
      txData = {$urandom, $urandom};
      txK = 8'($urandom);
    end
  end
endmodule

// ===== pspl_phy_status_tb.sv
// Self-checking bench for the PHY status and master loopback port block
`timescale 1ns/10ps
`include "pspl_cfg.svh"

module pspl_phy_status_tb;
  logic                     clock = 1'b0;                   // Core clock
  logic                     rst_n = 1'b0;                   // Reset, active low
  pspl_pkg::pspl_ltssm_type trainState = pspl_pkg::PSPL_DETECT; // Trainer state
  logic                     pollSub = 1'b0;                 // Compliance substate
  logic [3:0]               laneIncl = 4'h0;                // Lanes in negotiation
  logic                     laneTxReady = 1'b0;             // Lanes accept words
  logic [63:0]              laneRxData = `PSPL_ZERO_D;      // Word from the lanes
  logic [7:0]               laneRxK = 8'h00;                // K flags from the lanes
  logic [63:0]              txLbkData;                      // User word
  logic [7:0]               txLbkK;                         // User K flags
  logic [3:0]               cfgLaneIncl;                    // Inclusion status
  logic [2:0]               linkWidth;                      // Width code
  logic                     polComp, txRdy, lTxValid;       // Single-bit outputs
  logic [63:0]              rxData, lTxData;                // Loopback words out
  logic [7:0]               rxK, lTxK;                      // Loopback K flags out
  logic [3:0]               eIncl;                          // Expected inclusion
  logic [2:0]               eWid;                           // Expected width
  logic                     ePol, eRdy, eVal;               // Expected flags
  logic [63:0]              eRx, eTx;                       // Expected words
  logic [7:0]               eRxK, eTxK;                     // Expected K flags
  logic [3:0]               incl2, incl1, eIncl2, eIncl1;   // Narrow builds: inclusion
  logic [2:0]               wid2, wid1, eWid2;              // Narrow builds: width
  logic                     pol2, rdy2, val2;               // Two-lane build: flags
  logic                     pol1, rdy1, val1;               // Single-lane build: flags
  logic [63:0]              rx2, tx2, rx1, tx1;             // Narrow builds: words
  logic [7:0]               rxK2, txK2, rxK1, txK1;         // Narrow builds: K flags
  localparam logic [63:0]   LOW2 = 64'h0000_0000_FFFF_FFFF; // Slices of lanes 1 and 0
  int                       n_errors = 0;                   // Mismatches
  int                       n_checks = 0;                   // Comparisons
  int                       seed;                           // Seeding result
  bit                       chkOn = 1'b0;                   // Outputs are defined

  // 100 MHz clock
  always #5 clock = ~clock;

  // Device under test, four-lane build with loopback
  pspl_phy_status u_dut
  (
    .clock(clock), .rst_n(rst_n), .trainState(trainState), .pollSubCompliance(pollSub),
    .laneIncluded(laneIncl), .laneTxReady(laneTxReady), .laneRxData(laneRxData),
    .laneRxK(laneRxK), .txLbkData(txLbkData), .txLbkK(txLbkK), .cfgLaneIncl_ff(cfgLaneIncl),
    .linkWidth_ff(linkWidth), .polCompliance_ff(polComp), .txLbkReady_ff(txRdy),
    .rxLbkData_ff(rxData), .rxLbkK_ff(rxK), .laneTxData_ff(lTxData), .laneTxK_ff(lTxK),
    .laneTxValid_ff(lTxValid)
  );

  // Two-lane five-gigabit build with loopback, same stimulus
  pspl_phy_status
  #(
    .BUILD       (pspl_pkg::PSPL_G2_X2),
    .LOOPBACK_EN (1'b1)
  )
  u_dut_x2
  (
    .clock(clock), .rst_n(rst_n), .trainState(trainState), .pollSubCompliance(pollSub),
    .laneIncluded(laneIncl), .laneTxReady(laneTxReady), .laneRxData(laneRxData),
    .laneRxK(laneRxK), .txLbkData(txLbkData), .txLbkK(txLbkK), .cfgLaneIncl_ff(incl2),
    .linkWidth_ff(wid2), .polCompliance_ff(pol2), .txLbkReady_ff(rdy2),
    .rxLbkData_ff(rx2), .rxLbkK_ff(rxK2), .laneTxData_ff(tx2), .laneTxK_ff(txK2),
    .laneTxValid_ff(val2)
  );

  // Native single-lane build without the loopback option, same stimulus
  pspl_phy_status
  #(
    .BUILD       (pspl_pkg::PSPL_G1_X1),
    .LOOPBACK_EN (1'b0)
  )
  u_dut_x1
  (
    .clock(clock), .rst_n(rst_n), .trainState(trainState), .pollSubCompliance(pollSub),
    .laneIncluded(laneIncl), .laneTxReady(laneTxReady), .laneRxData(laneRxData),
    .laneRxK(laneRxK), .txLbkData(txLbkData), .txLbkK(txLbkK), .cfgLaneIncl_ff(incl1),
    .linkWidth_ff(wid1), .polCompliance_ff(pol1), .txLbkReady_ff(rdy1),
    .rxLbkData_ff(rx1), .rxLbkK_ff(rxK1), .laneTxData_ff(tx1), .laneTxK_ff(txK1),
    .laneTxValid_ff(val1)
  );

  // User logic on the transmit side
  pspl_lbk_user u_user
  (
    .clock(clock), .rst_n(rst_n), .ready(txRdy), .txData(txLbkData), .txK(txLbkK)
  );

  // One-hot width from the included set
  function automatic logic [2:0] expWidth(input logic [3:0] l);
    expWidth = (l == 4'hF) ? 3'h4 : (l == 4'h3) ? 3'h2 : (l == 4'h1) ? 3'h1 : 3'h0;
  endfunction

  // Inclusion vector of a build with n lanes: highest present lane in bit 0
  function automatic logic [3:0] expIncl(input logic [3:0] l, input int n);
    expIncl = (n == 4) ? {l[0], l[1], l[2], l[3]} : (n == 2) ? {2'h0, l[0], l[1]} : {3'h0, l[0]};
  endfunction

  // Reference model, one cycle behind the inputs
  always @(posedge clock)
  begin
    if (!rst_n)
      {eIncl, eIncl2, eIncl1, eWid, eWid2, ePol, eRdy, eVal, eRx, eRxK, eTx, eTxK} = '0;
    else
    begin
      eVal = eRdy;
      if (eRdy)
        {eTx, eTxK} = {txLbkData, txLbkK};
      eRdy = (trainState == pspl_pkg::PSPL_LOOPBACK) && laneTxReady;
      eIncl = (trainState == pspl_pkg::PSPL_CONFIG) ? expIncl(laneIncl, 4) : 4'h0;
      eIncl2 = (trainState == pspl_pkg::PSPL_CONFIG) ? expIncl(laneIncl, 2) : 4'h0;
      eIncl1 = (trainState == pspl_pkg::PSPL_CONFIG) ? expIncl(laneIncl, 1) : 4'h0;
      if (trainState == pspl_pkg::PSPL_DETECT)
      begin
        eWid = 3'h0;
        eWid2 = 3'h0;
      end
      else if (trainState == pspl_pkg::PSPL_CONFIG)
      begin
        eWid = expWidth(laneIncl);
        eWid2 = expWidth(laneIncl & 4'h3);
      end
      ePol = (trainState == pspl_pkg::PSPL_POLLING) && pollSub;
      {eRx, eRxK} = {laneRxData, laneRxK};
    end
  end

  // Compares a status value
  task automatic check_stat(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t status got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares a loopback word or flag field
  task automatic check_data(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t data got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Output checks where every output has settled
  always @(negedge clock)
  begin
    if (chkOn)
    begin
      check_stat(8'(cfgLaneIncl), 8'(eIncl));
      check_stat(8'(linkWidth), 8'(eWid));
      check_stat(8'(polComp), 8'(ePol));
      check_stat(8'(txRdy), 8'(eRdy));
      check_stat(8'(lTxValid), 8'(eVal));
      check_data(rxData, eRx);
      check_data(64'(rxK), 64'(eRxK));
      check_data(lTxData, eTx);
      check_data(64'(lTxK), 64'(eTxK));
      check_stat(8'(incl2), 8'(eIncl2));
      check_stat(8'(wid2), 8'(eWid2));
      check_stat(8'({pol2, rdy2, val2}), 8'({ePol, eRdy, eVal}));
      check_data(rx2, eRx & LOW2);
      check_data(64'({rxK2, txK2}), 64'({eRxK, eTxK} & 16'h0F0F));
      check_data(tx2, eTx & LOW2);
      check_stat(8'(incl1), 8'(eIncl1));
      check_stat(8'({wid1, pol1, rdy1, val1}), 8'({3'h0, ePol, 2'h0}));
      check_data(rx1, `PSPL_ZERO_D);
      check_data(tx1, `PSPL_ZERO_D);
      check_data(64'({rxK1, txK1}), `PSPL_ZERO_D);
    end
  end

  // Drives one test: 0 random status, 1 config corners, 2 loopback, 3 loopback with reset
  task automatic run_test(input int kind, input int cycles);
    logic [3:0] lt [4];
    lt = '{4'hF, 4'h3, 4'h1, 4'h6};
    for (int i = 0; i < cycles; i++)
    begin
      @(negedge clock);
      laneRxData = {$urandom, $urandom};
      laneRxK = 8'($urandom);
      pollSub = 1'($urandom);
      laneIncl = 4'($urandom);
      if (kind == 0)
        trainState = pspl_pkg::pspl_ltssm_type'($urandom_range(10));
      else if (kind == 1)
      begin
        // Config, hold in another state, clear in Detect
        trainState = (i % 3 == 0) ? pspl_pkg::PSPL_CONFIG :
                     (i % 3 == 1) ? pspl_pkg::PSPL_L0 : pspl_pkg::PSPL_DETECT;
        laneIncl = lt[i % 4];
      end
      else
      begin
        // Mostly loopback, back-to-back ready runs, brief exits
        trainState = ($urandom_range(7) == 0) ? pspl_pkg::PSPL_L0 : pspl_pkg::PSPL_LOOPBACK;
        laneTxReady = ($urandom_range(3) != 0);
        rst_n = !(kind == 3 && i >= 40 && i < 43);
      end
    end
    $display("Test %0d done, errors so far %0d", kind, n_errors);
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic finish_test;
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    seed = $urandom(73);
    @(posedge clock);
    chkOn = 1'b1;
    repeat (11) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    for (int k = 0; k < 4; k++)
      run_test(k, 200);
    finish_test;
  end

  // Watchdog, well past the expected 812 cycles
  initial
  begin
    #20000;
    n_errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    finish_test;
  end
endmodule
